/* bil_boot_loader.sv */
`timescale 1ns/1ps
`include "bil_consts.svh"
`default_nettype none

// Behaviour
// - Secure boot set: image comes from OTP address zero, boot pins ignored.
// - Secure boot is bit 5 of the OTP security configuration word.
// - Boot pins sampled after reset with pull-downs on; all low means quad flash.
// - Image is length word, length times four bytes, then CRC or skip value.
// - Length and CRC words arrive least significant byte first.
// - Words are written from RAM address zero; execution starts at zero.
// - Reflected CRC-32 over length and program bytes, final residue inverted.
// - Quad boot drives clock and select, sends 0xEB, three zero addresses, dummy.
// - After command, address and dummy the four data lines become inputs.
// - Both flash sources use clock polarity zero and phase zero.
// - Quad bytes take the low nibble first.
// - SPI flash boot sends 0x03, three zero addresses, no dummy, then reads.
// - Single-bit SPI sources take the least significant bit first.
// - SPI slave takes data from first rising edge, modes 0/0 and 1/1.
// - Link boot drops pull-downs, drives transmit wires low, watches receive.
// - Link boot allocates channel end zero and reads the acknowledge word.
// - Link image with CRC is followed by an END token that must arrive.
// - After END, send END to acknowledge target, free channel end, start.
module bil_boot_loader #(
  parameter int RAM_AW = 17,
  parameter int SCLK_HALF = 4,
  parameter int LINK_W = 5,
  parameter logic [2:0] PAT_SPIM = 3'h1,
  parameter logic [2:0] PAT_SPIS = 3'h2,
  parameter logic [2:0] PAT_LINK = 3'h4
) (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // OTP read port
  output logic [9:0] o_otp_addr,
  input wire logic [31:0] i_otp_data,
  // Flash and boot pins
  output logic o_flash_select_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_oe,
  input wire logic [3:0] i_quad_data,
  output logic [3:0] o_quad_data,
  output logic [3:0] o_quad_data_oe,
  output logic o_pull_down_en,
  // SPI slave pins
  input wire logic i_serial_clock_pin,
  input wire logic i_slave_select_pin_n,
  input wire logic i_slave_data_in_pin,
  // Link channel
  input wire logic i_link_rx_valid,
  input wire bil_pkg::bil_tok_s i_link_rx,
  output logic o_link_tx_valid,
  output var bil_pkg::bil_tok_s o_link_tx,
  output logic [31:0] o_link_tx_dest,
  output logic [LINK_W-1:0] o_link_tx_wires,
  output logic o_chanend0_alloc,
  // RAM and start
  output logic o_ram_we,
  output logic [RAM_AW-1:0] o_ram_addr,
  output logic [31:0] o_ram_wdata,
  output logic o_run,
  output logic [RAM_AW-1:0] o_run_addr,
  output logic o_boot_fail
);

  function automatic logic [31:0] bil_crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `BIL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  bil_pkg::bil_st_e st_q, st_d;
  bil_pkg::bil_src_e src_q, src_d;
  logic [3:0] cnt_q, s1_q, s2_q, s3_q, filt_q;
  logic [1:0] k_q, bc_q;
  logic [31:0] w_q, len_q, crc_q, ack_q;
  logic ok_q;
  logic [3:0] div_q, oe_q, dq_q, lo_q;
  logic fl_on_q, sclk_q, cs_q, inph_q, nib_q, fbv_q, run_q, fail_q, pd_q, we_q, tx_v_q;
  logic [31:0] sr_q, wd_q;
  logic [5:0] ocnt_q;
  logic [2:0] fbit_q;
  logic [7:0] fsr_q, fbd_q;
  logic [RAM_AW-1:0] addr_q, ra_q;
  logic [9:0] otp_q;
  bil_pkg::bil_tok_s tx_q;
  logic alloc_q;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      filt_q <= 4'h0;
    end else if (i_clk_en) begin
      s1_q <= i_quad_data;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 4; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  // ----------------------------------------
  // SPI slave capture on the master's clock
  // ----------------------------------------
  // Both supported modes sample on the rising edge, so one process serves both.
  logic [2:0] sbc_q;
  logic [7:0] ssr_q, shold_q;
  logic stog_q;
  always_ff @(posedge i_serial_clock_pin or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sbc_q <= 3'h0;
      ssr_q <= 8'h00;
      shold_q <= 8'h00;
      stog_q <= 1'b0;
    end else if (i_slave_select_pin_n) begin
      sbc_q <= 3'h0;
    end else begin
      ssr_q <= {i_slave_data_in_pin, ssr_q[7:1]};
      sbc_q <= sbc_q + 3'h1;
      if (sbc_q == 3'h7) begin
        shold_q <= {i_slave_data_in_pin, ssr_q[7:1]};
        stog_q <= ~stog_q;
      end
    end
  end

  // Toggle crossing; the held byte is stable for a whole byte time afterwards
  logic [2:0] t_q;
  logic tseen_q;
  wire sev = (t_q[1] == t_q[2]) && (t_q[2] != tseen_q);
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      t_q <= 3'h0;
      tseen_q <= 1'b0;
    end else if (i_clk_en) begin
      t_q <= {t_q[1:0], stog_q};
      if (t_q[1] == t_q[2]) begin
        tseen_q <= t_q[2];
      end
    end
  end

  // ----------------------------------------
  // Byte source selection
  // ----------------------------------------
  wire img = (st_q == bil_pkg::ST_ACK) || (st_q == bil_pkg::ST_LEN) ||
             (st_q == bil_pkg::ST_PROG) || (st_q == bil_pkg::ST_CRC);
  wire lrx_d = i_link_rx_valid && !i_link_rx.ctrl;
  wire lrx_end = i_link_rx_valid && i_link_rx.ctrl && (i_link_rx.data == `BIL_END_TOKEN);
  wire [31:0] otp_sh = i_otp_data >> {k_q, 3'b000};
  wire is_otp = src_q == bil_pkg::SRC_OTP;
  wire is_spis = src_q == bil_pkg::SRC_SPIS;
  wire is_link = src_q == bil_pkg::SRC_LINK;
  wire quad = src_q == bil_pkg::SRC_QUAD;
  wire bv = img && (is_otp ? 1'b1 : is_spis ? sev : is_link ? lrx_d : fbv_q);
  wire [7:0] bd = is_otp ? otp_sh[7:0] : is_spis ? shold_q : is_link ? i_link_rx.data : fbd_q;
  wire wfull = bv && (bc_q == 2'h3);
  wire [31:0] word = {bd, w_q[31:8]};
  wire [31:0] crc_n = bil_crc_byte(crc_q, bd);
  wire ok_n = (word == `BIL_CRC_SKIP) || (word == ~crc_q);
  wire sec = i_otp_data[`BIL_SEC_BOOT_BIT];
  wire [2:0] strap = filt_q[2:0];

  // ----------------------------------------
  // Boot sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    src_d = src_q;
    unique case (st_q)
      bil_pkg::ST_WAIT: if (cnt_q == 4'(`BIL_STRAP_CYC - 1)) st_d = bil_pkg::ST_SEC;
      bil_pkg::ST_SEC: begin
        if (sec) src_d = bil_pkg::SRC_OTP;
        else if (strap == PAT_SPIM) src_d = bil_pkg::SRC_SPIM;
        else if (strap == PAT_SPIS) src_d = bil_pkg::SRC_SPIS;
        else if (strap == PAT_LINK) src_d = bil_pkg::SRC_LINK;
        else src_d = bil_pkg::SRC_QUAD;
        st_d = (src_d == bil_pkg::SRC_LINK) ? bil_pkg::ST_ACK : bil_pkg::ST_LEN;
      end
      bil_pkg::ST_ACK: if (wfull) st_d = bil_pkg::ST_LEN;
      bil_pkg::ST_LEN: if (wfull) st_d = (word == 32'h0) ? bil_pkg::ST_CRC : bil_pkg::ST_PROG;
      bil_pkg::ST_PROG: if (wfull && len_q == 32'h1) st_d = bil_pkg::ST_CRC;
      bil_pkg::ST_CRC: begin
        if (wfull) begin
          st_d = is_link ? bil_pkg::ST_END : ok_n ? bil_pkg::ST_RUN : bil_pkg::ST_FAIL;
        end
      end
      bil_pkg::ST_END: if (lrx_end) st_d = bil_pkg::ST_SEND;
      bil_pkg::ST_SEND: st_d = ok_q ? bil_pkg::ST_RUN : bil_pkg::ST_FAIL;
      bil_pkg::ST_RUN: st_d = st_q;
      bil_pkg::ST_FAIL: st_d = st_q;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= bil_pkg::ST_WAIT;
      src_q <= bil_pkg::SRC_QUAD;
      cnt_q <= 4'h0;
    end else if (i_clk_en) begin
      st_q <= st_d;
      src_q <= src_d;
      if (st_q == bil_pkg::ST_WAIT) cnt_q <= cnt_q + 4'h1;
    end
  end

  // Word assembly, CRC and RAM writes
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bc_q <= 2'h0;
      w_q <= 32'h0;
      len_q <= 32'h0;
      ack_q <= `BIL_NULL_CHANEND;
      crc_q <= `BIL_CRC_INIT;
      ok_q <= 1'b0;
      addr_q <= '0;
      we_q <= 1'b0;
      ra_q <= '0;
      wd_q <= 32'h0;
    end else if (i_clk_en) begin
      we_q <= 1'b0;
      if (st_q == bil_pkg::ST_SEC) crc_q <= `BIL_CRC_INIT;
      if (bv) begin
        bc_q <= bc_q + 2'h1;
        w_q <= word;
        if (st_q == bil_pkg::ST_LEN || st_q == bil_pkg::ST_PROG) crc_q <= crc_n;
      end
      if (wfull && st_q == bil_pkg::ST_ACK) ack_q <= word;
      if (wfull && st_q == bil_pkg::ST_LEN) len_q <= word;
      if (wfull && st_q == bil_pkg::ST_CRC) ok_q <= ok_n;
      if (wfull && st_q == bil_pkg::ST_PROG) begin
        we_q <= 1'b1;
        ra_q <= addr_q;
        wd_q <= word;
        addr_q <= addr_q + RAM_AW'(1);
        len_q <= len_q - 32'h1;
      end
    end
  end

  // OTP walk: secure word first, then image words
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      otp_q <= `BIL_OTP_SEC_ADDR;
      k_q <= 2'h0;
    end else if (i_clk_en) begin
      if (st_q == bil_pkg::ST_SEC) otp_q <= `BIL_OTP_IMG_ADDR;
      if (bv && is_otp) begin
        k_q <= k_q + 2'h1;
        if (k_q == 2'h3) otp_q <= otp_q + 10'h001;
      end
    end
  end

  // ----------------------------------------
  // Flash master, mode 0/0
  // ----------------------------------------
  wire fl_go = (st_q == bil_pkg::ST_SEC) && (src_d == bil_pkg::SRC_QUAD ||
               src_d == bil_pkg::SRC_SPIM);
  wire fl_stop = (st_q == bil_pkg::ST_RUN) || (st_q == bil_pkg::ST_FAIL);
  wire tick = fl_on_q && (div_q == 4'(SCLK_HALF - 1));
  wire rise = tick && !sclk_q;
  wire fall = tick && sclk_q;
  wire qph = quad && (ocnt_q <= `BIL_QUAD_SPLIT);
  wire [31:0] sr_n = qph ? (sr_q << 4) : (sr_q << 1);
  wire [7:0] fcmd = (src_d == bil_pkg::SRC_QUAD) ? `BIL_QUAD_CMD : `BIL_SPI_CMD;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fl_on_q <= 1'b0;
      div_q <= 4'h0;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else if (i_clk_en) begin
      div_q <= tick ? 4'h0 : (fl_on_q ? div_q + 4'h1 : 4'h0);
      if (tick) sclk_q <= ~sclk_q;
      if (fl_go) begin
        fl_on_q <= 1'b1;
        cs_q <= 1'b0;
        sclk_q <= 1'b0;
      end else if (fl_stop && fl_on_q && !sclk_q) begin
        fl_on_q <= 1'b0;
        cs_q <= 1'b1;
      end
    end
  end

  // Command out on falling edges, bits counted on rising edges
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sr_q <= 32'h0;
      ocnt_q <= 6'h0;
      oe_q <= 4'h0;
      dq_q <= 4'h0;
      inph_q <= 1'b0;
    end else if (i_clk_en) begin
      if (fl_go) begin
        sr_q <= {fcmd, `BIL_ADDR_BYTE, `BIL_ADDR_BYTE, `BIL_ADDR_BYTE};
        ocnt_q <= (src_d == bil_pkg::SRC_QUAD) ? `BIL_QUAD_OUT : `BIL_SPI_OUT;
        oe_q <= 4'h1;
        dq_q <= {3'h0, fcmd[7]};
        inph_q <= 1'b0;
      end else if (fl_stop) begin
        oe_q <= 4'h0;
      end else if (rise && !inph_q) begin
        ocnt_q <= ocnt_q - 6'h01;
      end else if (fall && !inph_q) begin
        sr_q <= sr_n;
        dq_q <= qph ? sr_n[31:28] : {3'h0, sr_n[31]};
        oe_q <= (ocnt_q == 6'h0) ? 4'h0 : qph ? 4'hF : 4'h1;
        inph_q <= (ocnt_q == 6'h0);
      end
    end
  end

  // Read data taken at the falling tick: the filtered pins trail the rise by four cycles
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      nib_q <= 1'b0;
      lo_q <= 4'h0;
      fbit_q <= 3'h0;
      fsr_q <= 8'h00;
      fbv_q <= 1'b0;
      fbd_q <= 8'h00;
    end else if (i_clk_en) begin
      fbv_q <= 1'b0;
      if (fall && inph_q && quad) begin
        nib_q <= ~nib_q;
        if (!nib_q) lo_q <= filt_q;
        else begin
          fbv_q <= 1'b1;
          fbd_q <= {filt_q, lo_q};
        end
      end else if (fall && inph_q) begin
        fsr_q <= {filt_q[1], fsr_q[7:1]};
        fbit_q <= fbit_q + 3'h1;
        if (fbit_q == 3'h7) begin
          fbv_q <= 1'b1;
          fbd_q <= {filt_q[1], fsr_q[7:1]};
        end
      end
    end
  end

  // ----------------------------------------
  // Link, pull-downs and start
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pd_q <= 1'b1;
      alloc_q <= 1'b0;
      tx_v_q <= 1'b0;
      tx_q <= '0;
      run_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (i_clk_en) begin
      tx_v_q <= 1'b0;
      if (st_q == bil_pkg::ST_SEC && src_d == bil_pkg::SRC_LINK) begin
        pd_q <= 1'b0;
        alloc_q <= 1'b1;
      end
      if (st_q == bil_pkg::ST_SEND) begin
        tx_v_q <= 1'b1;
        tx_q <= '{ctrl: 1'b1, data: `BIL_END_TOKEN};
        alloc_q <= 1'b0;
      end
      run_q <= (st_d == bil_pkg::ST_RUN) && (st_q != bil_pkg::ST_RUN);
      if (st_d == bil_pkg::ST_FAIL) fail_q <= 1'b1;
    end
  end

  assign o_otp_addr = otp_q;
  assign o_flash_select_pin = cs_q;
  assign o_serial_clock_pin = sclk_q;
  assign o_serial_clock_oe = fl_on_q;
  assign o_quad_data = dq_q;
  assign o_quad_data_oe = oe_q;
  assign o_pull_down_en = pd_q;
  assign o_link_tx_valid = tx_v_q;
  assign o_link_tx = tx_q;
  assign o_link_tx_dest = ack_q;
  assign o_link_tx_wires = '0;
  assign o_chanend0_alloc = alloc_q;
  assign o_ram_we = we_q;
  assign o_ram_addr = ra_q;
  assign o_ram_wdata = wd_q;
  assign o_run = run_q;
  assign o_run_addr = RAM_AW'(`BIL_RUN_ADDR);
  assign o_boot_fail = fail_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst || !i_clk_en);

  sequence s_crc_word;
    st_q == bil_pkg::ST_CRC && wfull;
  endsequence
  sequence s_end_seen;
    st_q == bil_pkg::ST_END && lrx_end;
  endsequence

  a_sec_forces_otp: assert property (st_q == bil_pkg::ST_SEC && sec |=> is_otp)
    else $error("secure boot did not select OTP");
  a_strap_quad: assert property (st_q == bil_pkg::ST_SEC && !sec && strap == 3'h0 |=> quad)
    else $error("all-low pins did not select quad flash");
  a_crc_start: assert property ($rose(st_q == bil_pkg::ST_LEN) |-> crc_q == `BIL_CRC_INIT)
    else $error("CRC not seeded at image start");
  a_skip_runs: assert property (s_crc_word ##0 word == `BIL_CRC_SKIP ##0 !is_link
    |=> run_q && !fail_q)
    else $error("skip value did not start program");
  a_bad_crc_stop: assert property (run_q |-> ok_q)
    else $error("program started after CRC mismatch");
  a_cmd_first: assert property ($fell(cs_q) |-> dq_q[0] == fcmd[7] && !sclk_q)
    else $error("flash command does not lead or clock not idle low");
  a_data_release: assert property (inph_q |-> oe_q == 4'h0)
    else $error("data lines driven during image read");
  a_end_reply: assert property (s_end_seen |=> st_q == bil_pkg::ST_SEND ##1 tx_v_q && tx_q.ctrl
    && !alloc_q)
    else $error("END reply missing after END token");

endmodule

`default_nettype wire

/* bil_consts.svh */
`ifndef BIL_CONSTS_SVH
`define BIL_CONSTS_SVH

// ----------------------------------------
// Security word and image format
// ----------------------------------------
`define BIL_OTP_SEC_ADDR 10'h000
`define BIL_OTP_IMG_ADDR 10'h000
`define BIL_SEC_BOOT_BIT 5
`define BIL_CRC_SKIP 32'h0D15AB1E
`define BIL_CRC_POLY 32'hEDB88320
`define BIL_CRC_INIT 32'h0FFFFFFF
`define BIL_RUN_ADDR 32'h00000000

// ----------------------------------------
// Flash commands
// ----------------------------------------
`define BIL_QUAD_CMD 8'hEB
`define BIL_SPI_CMD 8'h03
`define BIL_ADDR_BYTE 8'h00
`define BIL_QUAD_OUT 6'h10
`define BIL_QUAD_SPLIT 6'h08
`define BIL_SPI_OUT 6'h20

// ----------------------------------------
// Link tokens
// ----------------------------------------
`define BIL_NULL_CHANEND 32'h0000FF02
`define BIL_END_TOKEN 8'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define BIL_CLK_PERIOD_NS 100
`define BIL_STRAP_NS 1000
`define BIL_STRAP_CYC ((`BIL_STRAP_NS + `BIL_CLK_PERIOD_NS - 1) / `BIL_CLK_PERIOD_NS)

`endif

/* bil_pkg.sv */
package bil_pkg;

  typedef enum {SRC_QUAD, SRC_SPIM, SRC_SPIS, SRC_LINK, SRC_OTP} bil_src_e;

  typedef enum {ST_WAIT, ST_SEC, ST_ACK, ST_LEN, ST_PROG, ST_CRC, ST_END, ST_SEND, ST_RUN,
                ST_FAIL} bil_st_e;

  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } bil_tok_s;

endpackage

/* bil_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Serial flash, quad or single-bit
// ----------------------------------------
module bil_flash_model (
  // Bus from the loader
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_data,
  // Flash type: quad when high
  input wire logic i_quad,
  // Drive toward the pins
  output logic [3:0] o_data,
  output logic [3:0] o_oe,
  // What the loader sent
  output logic [7:0] o_cmd,
  output logic o_addr_nz
);
  logic [7:0] img[$];
  int rises;
  int pos;
  int idx;

  initial begin
    o_data = 4'h0;
    o_oe = 4'h0;
    o_cmd = 8'h00;
    o_addr_nz = 1'b0;
    rises = 0;
    pos = 0;
  end

  // Ready at once, single-line command in power-up state
  always @(negedge i_cs_n) begin
    rises = 0;
    pos = 0;
    o_cmd = 8'h00;
    o_addr_nz = 1'b0;
  end

  // Released lines fall back to their pull level
  always @(posedge i_cs_n) o_oe = 4'h0;

  always @(posedge i_sclk) begin
    if (i_cs_n === 1'b0) begin
      if (rises < 8) begin
        o_cmd = {o_cmd[6:0], i_data[0]};
      end else if (rises < (i_quad ? 16 : 32)) begin
        o_addr_nz = o_addr_nz | (i_quad ? |i_data : i_data[0]);
      end
      rises++;
    end
  end

  // Mode 0: data moves on the falling edge, held through the rise
  always @(negedge i_sclk) begin
    if (i_cs_n === 1'b0 && rises >= (i_quad ? 16 : 32)) begin
      idx = i_quad ? pos / 2 : pos / 8;
      if (idx >= img.size()) begin
        o_data = ~o_data;
      end else if (i_quad) begin
        o_data = pos[0] ? img[idx][7:4] : img[idx][3:0];
      end else begin
        o_data = {2'b00, img[idx][pos % 8], 1'b0};
      end
      o_oe = i_quad ? 4'hF : 4'h2;
      pos++;
    end
  end
endmodule

`default_nettype wire

/* bil_boot_loader_tb.sv */
`timescale 1ns/1ps
`include "bil_consts.svh"
`default_nettype none

module bil_boot_loader_tb;
  localparam time DLY = 10;
  localparam int LIMIT = 20000;
  localparam logic [2:0] PAT_SPIM = 3'h1;
  localparam logic [2:0] PAT_SPIS = 3'h2;
  localparam logic [2:0] PAT_LINK = 3'h4;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] strap = 4'h0;
  logic fl_quad = 1'b1;
  logic sclk_s = 1'b0;
  logic ss_n = 1'b1;
  logic mosi = 1'b0;
  // Remote keeps the link quiet until it sends
  logic rx_valid = 1'b0;
  bil_pkg::bil_tok_s rx_tok = '0;
  logic [31:0] otp [0:1023];
  wire logic [9:0] otp_addr;
  wire logic [31:0] otp_data, tx_dest, ram_wdata;
  wire logic cs_n, sclk, sclk_oe, fail, run, ram_we, tx_valid, alloc, pd_en, fl_addr_nz;
  wire logic [3:0] dq_o, dq_oe, fl_d, fl_oe, dq;
  wire logic [7:0] fl_cmd;
  wire bil_pkg::bil_tok_s tx_tok;
  wire logic [16:0] ram_addr, run_addr;
  wire logic [4:0] tx_wires;
  logic [7:0] img[$];
  logic [31:0] ram_a[$];
  logic [31:0] ram_d[$];
  int run_cnt = 0;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  always #50 i_clock = ~i_clock;
  // Undriven pins sit at their strap pull level
  assign dq = (dq_oe & dq_o) | (~dq_oe & fl_oe & fl_d) | (~dq_oe & ~fl_oe & strap);
  assign otp_data = otp[otp_addr];

  bil_boot_loader #(.PAT_SPIM(PAT_SPIM), .PAT_SPIS(PAT_SPIS), .PAT_LINK(PAT_LINK)) dut_u (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
    .o_otp_addr(otp_addr), .i_otp_data(otp_data),
    .o_flash_select_pin(cs_n), .o_serial_clock_pin(sclk), .o_serial_clock_oe(sclk_oe),
    .i_quad_data(dq), .o_quad_data(dq_o), .o_quad_data_oe(dq_oe), .o_pull_down_en(pd_en),
    .i_serial_clock_pin(sclk_s), .i_slave_select_pin_n(ss_n), .i_slave_data_in_pin(mosi),
    .i_link_rx_valid(rx_valid), .i_link_rx(rx_tok), .o_link_tx_valid(tx_valid),
    .o_link_tx(tx_tok), .o_link_tx_dest(tx_dest), .o_link_tx_wires(tx_wires),
    .o_chanend0_alloc(alloc), .o_ram_we(ram_we), .o_ram_addr(ram_addr),
    .o_ram_wdata(ram_wdata), .o_run(run), .o_run_addr(run_addr), .o_boot_fail(fail)
  );

  bil_flash_model fl_u (
    .i_cs_n(cs_n), .i_sclk(sclk), .i_data(dq), .i_quad(fl_quad),
    .o_data(fl_d), .o_oe(fl_oe), .o_cmd(fl_cmd), .o_addr_nz(fl_addr_nz)
  );

  always @(posedge i_clock) begin
    if (ram_we === 1'b1) begin
      ram_a.push_back({15'h0, ram_addr});
      ram_d.push_back(ram_wdata);
    end
    if (run === 1'b1) run_cnt++;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge i_clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic [3:0] s);
    @(posedge i_clock);
    #DLY;
    strap = s;
    i_sys_rst = 1'b1;
    repeat (3) @(posedge i_clock);
    ram_a.delete();
    ram_d.delete();
    run_cnt = 0;
    #DLY i_sys_rst = 1'b0;
  endtask

  task automatic push_word(input logic [31:0] w);
    for (int b = 0; b < 4; b++) img.push_back(w[8*b +: 8]);
  endtask

  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = `BIL_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, img[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ `BIL_CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction

  // Mode 0 good CRC, 1 skip value, 2 corrupted CRC
  task automatic build_img(input int nw, input int mode);
    logic [31:0] crc;
    img.delete();
    push_word(32'(nw));
    for (int k = 0; k < nw; k++) push_word(32'hC3A50F1E + 32'(k) * 32'h01020408);
    crc = (mode == 1) ? `BIL_CRC_SKIP : crc_of(img.size());
    if (mode == 2) crc = crc ^ 32'h00000100;
    push_word(crc);
  endtask

  task automatic wait_done(input logic exp_run);
    for (int k = 0; k < 6000; k++) begin
      @(posedge i_clock);
      if (run_cnt > 0 || fail === 1'b1) break;
    end
    repeat (3) @(posedge i_clock);
    #DLY;
    check(32'(run_cnt), {31'h0, exp_run});
    check({31'h0, fail}, {31'h0, ~exp_run});
    check({15'h0, run_addr}, `BIL_RUN_ADDR);
  endtask

  task automatic check_ram(input int nw);
    check(32'(ram_a.size()), 32'(nw));
    for (int k = 0; k < nw && k < ram_a.size(); k++) begin
      check(ram_a[k], 32'(k));
      check(ram_d[k], {img[4*k+7], img[4*k+6], img[4*k+5], img[4*k+4]});
    end
  endtask

  task automatic send_tok(input logic c, input logic [7:0] d);
    @(posedge i_clock);
    #DLY;
    rx_valid = 1'b1;
    rx_tok.ctrl = c;
    rx_tok.data = d;
    @(posedge i_clock);
    #DLY;
    rx_valid = 1'b0;
    rx_tok.data = ~d;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic boot_quad();
    build_img(2, 0);
    fl_quad = 1'b1;
    fl_u.img = img;
    do_reset(4'h0);
    wait_done(1'b1);
    check({24'h0, fl_cmd}, {24'h0, `BIL_QUAD_CMD});
    check({31'h0, fl_addr_nz}, 32'h0);
    check({31'h0, sclk}, 32'h0);
    check({31'h0, sclk_oe}, 32'h0);
    check_ram(2);
  endtask

  task automatic boot_bad_crc();
    build_img(1, 2);
    fl_u.img = img;
    do_reset(4'h0);
    wait_done(1'b0);
  endtask

  task automatic boot_spim();
    build_img(1, 1);
    fl_quad = 1'b0;
    fl_u.img = img;
    do_reset({1'b0, PAT_SPIM});
    wait_done(1'b1);
    check({24'h0, fl_cmd}, {24'h0, `BIL_SPI_CMD});
    check({31'h0, fl_addr_nz}, 32'h0);
    check_ram(1);
  endtask

  // Both clock modes; bytes spaced by idle clock, LSB first
  task automatic boot_spis();
    for (int m = 0; m < 2; m++) begin
      build_img(2 - m, m);
      do_reset({1'b0, PAT_SPIS});
      repeat (15) @(posedge i_clock);
      #3 sclk_s = m[0];
      #3 ss_n = 1'b0;
      foreach (img[i]) begin
        for (int b = 0; b < 8; b++) begin
          sclk_s = 1'b0;
          mosi = img[i][b];
          #6 sclk_s = 1'b1;
          #6;
        end
        sclk_s = m[0];
        mosi = ~mosi;
        #1000;
      end
      ss_n = 1'b1;
      wait_done(1'b1);
      check_ram(2 - m);
    end
  endtask

  task automatic boot_link();
    logic [7:0] ack[4] = '{8'h5A, 8'h3C, 8'h3C, 8'h5A};
    build_img(1, 0);
    do_reset({1'b0, PAT_LINK});
    repeat (20) @(posedge i_clock);
    #DLY;
    check({31'h0, pd_en}, 32'h0);
    check({27'h0, tx_wires}, 32'h0);
    check({31'h0, alloc}, 32'h1);
    foreach (ack[i]) send_tok(1'b0, ack[i]);
    foreach (img[i]) send_tok(1'b0, img[i]);
    send_tok(1'b1, `BIL_END_TOKEN);
    for (int k = 0; k < 20; k++) begin
      @(posedge i_clock);
      #1;
      if (tx_valid === 1'b1) break;
    end
    check({22'h0, tx_valid, tx_tok}, {22'h0, 1'b1, 1'b1, `BIL_END_TOKEN});
    check(tx_dest, 32'h5A3C3C5A);
    wait_done(1'b1);
    check({31'h0, alloc}, 32'h0);
    check_ram(1);
  endtask

  // Length 0x20 doubles as the security word with bit 5 set
  task automatic boot_otp();
    build_img(32, 0);
    for (int i = 0; i < img.size() / 4; i++) begin
      otp[i] = {img[4*i+3], img[4*i+2], img[4*i+1], img[4*i]};
    end
    do_reset({1'b0, PAT_SPIS});
    wait_done(1'b1);
    check({31'h0, cs_n}, 32'h1);
    check_ram(32);
  endtask

  initial begin
    foreach (otp[i]) otp[i] = 32'h0;
    boot_quad();
    boot_bad_crc();
    boot_spim();
    boot_spis();
    boot_link();
    boot_otp();
    print_verdict();
  end
endmodule

`default_nettype wire
